// ### src/ufa_consts.svh
// Constants for the user flash array access block.
`ifndef UFA_CONSTS_SVH
`define UFA_CONSTS_SVH

`define UFA_ADDR_W        9
`define UFA_DATA_W        16
`define UFA_WORDS         512
`define UFA_SECT_WORDS    256
`define UFA_SECT_BIT      8
`define UFA_ERASED        16'hFFFF
`define UFA_CLK_PERIOD_NS 100
`define UFA_PROG_TIME_NS  2000
`define UFA_ERASE_TIME_NS 50000
`define UFA_CNT_W         12
`define UFA_PROG_CYC  ((`UFA_PROG_TIME_NS + `UFA_CLK_PERIOD_NS - 1) / `UFA_CLK_PERIOD_NS)
`define UFA_ERASE_CYC ((`UFA_ERASE_TIME_NS + `UFA_CLK_PERIOD_NS - 1) / `UFA_CLK_PERIOD_NS)

`endif

// ### src/ufa_pkg.sv
// Types for the user flash array access block.
`include "ufa_consts.svh"

package ufa_pkg;

    typedef enum logic [1:0] {
        UFA_ST_IDLE  = 2'b00,
        UFA_ST_PROG  = 2'b01,
        UFA_ST_ERASE = 2'b11
    } ufa_state_e;

    typedef enum logic [1:0] {
        UFA_CMD_READ  = 2'b00,
        UFA_CMD_PROG  = 2'b01,
        UFA_CMD_ERASE = 2'b10
    } ufa_cmd_e;

    typedef logic [`UFA_ADDR_W-1:0] ufa_addr_t;
    typedef logic [`UFA_DATA_W-1:0] ufa_word_t;

    typedef struct packed {
        logic data_reg_clock;
        logic data_reg_shift_select;
        logic data_reg_serial_in;
        logic addr_reg_clock;
        logic addr_reg_shift_select;
        logic addr_reg_serial_in;
        logic program_req;
        logic erase_req;
    } ufa_fabric_s;

    typedef struct packed {
        logic      req;
        ufa_cmd_e  cmd;
        ufa_addr_t addr;
        ufa_word_t wdata;
    } ufa_test_req_s;

    typedef struct packed {
        ufa_state_e            st;
        logic [`UFA_CNT_W-1:0] cnt;
        ufa_addr_t             areg;
        ufa_word_t             dreg;
        logic                  dout;
        logic                  busy;
        ufa_addr_t             op_addr;
        ufa_word_t             op_data;
        logic                  from_test;
        logic                  tp_done;
        ufa_word_t             tp_rdata;
        logic                  dclk_prev;
        logic                  aclk_prev;
        logic                  prog_prev;
        logic                  erase_prev;
    } ufa_state_s;

endpackage

// ### src/ufa_top.sv
// User flash array with serial fabric port and test port access.
// Functional notes
// - Two sectors of 4,096 bits; erasing one leaves the other intact.
// - 512 word locations addressed by 9 bits, 000h to 1FFh.
// - Each location holds a 16-bit word; reads and programs move all 16.
// - Address MSB selects sector: 000h-0FFh sector 0, 100h-1FFh sector 1.
// - The array is reachable from the fabric port and the test port.
// - The fabric port has no path to the configuration flash.
// - Data register shifts LSB to MSB when shift high, else loads word.
// - Address register shifts in a bit, or increments by one and wraps.
// - Fabric program and erase start on rising edges; busy stays high until done.
`timescale 1ns/10ps
`include "ufa_consts.svh"

module ufa_top (
    input  wire logic                  core_clk,
    input  wire logic                  reset_n,
    input  wire ufa_pkg::ufa_fabric_s  fabric,
    input  wire ufa_pkg::ufa_test_req_s test_req,
    output logic                       data_reg_serial_out,
    output logic                       busy,
    output logic                       test_done,
    output ufa_pkg::ufa_word_t         test_rdata
);
    import ufa_pkg::*;

    // Only the user array exists behind this port.
    ufa_word_t  mem_q [`UFA_WORDS];
    ufa_state_s s_q;
    ufa_state_s s_d;
    logic       mem_we;
    logic       mem_erase;
    logic       dclk_rise;
    logic       aclk_rise;
    logic       prog_rise;
    logic       erase_rise;
    ufa_word_t  rd_word;

    function automatic logic sector_of(input ufa_addr_t a);
        return a[`UFA_SECT_BIT];
    endfunction

    assign dclk_rise  = fabric.data_reg_clock & ~s_q.dclk_prev;
    assign aclk_rise  = fabric.addr_reg_clock & ~s_q.aclk_prev;
    assign prog_rise  = fabric.program_req & ~s_q.prog_prev;
    assign erase_rise = fabric.erase_req & ~s_q.erase_prev;
    assign rd_word    = mem_q[s_q.areg];

    always_comb begin
        s_d            = s_q;
        mem_we         = 1'b0;
        mem_erase      = 1'b0;
        s_d.tp_done    = 1'b0;
        s_d.dclk_prev  = fabric.data_reg_clock;
        s_d.aclk_prev  = fabric.addr_reg_clock;
        s_d.prog_prev  = fabric.program_req;
        s_d.erase_prev = fabric.erase_req;
        case (s_q.st)
            UFA_ST_IDLE: begin
                // Register clocks are honoured only while idle.
                if (dclk_rise) begin
                    if (fabric.data_reg_shift_select) begin
                        s_d.dreg = {s_q.dreg[`UFA_DATA_W-2:0],
                                    fabric.data_reg_serial_in};
                    end else begin
                        s_d.dreg = rd_word;
                    end
                    s_d.dout = s_d.dreg[`UFA_DATA_W-1];
                end
                if (aclk_rise) begin
                    if (fabric.addr_reg_shift_select) begin
                        s_d.areg = {s_q.areg[`UFA_ADDR_W-2:0],
                                    fabric.addr_reg_serial_in};
                    end else begin
                        // Natural 9-bit overflow gives the wrap.
                        s_d.areg = s_q.areg + ufa_addr_t'(1);
                    end
                end
                // Fabric requests win over a test request in the same cycle.
                if (prog_rise) begin
                    s_d.st        = UFA_ST_PROG;
                    s_d.cnt       = `UFA_CNT_W'(`UFA_PROG_CYC);
                    s_d.busy      = 1'b1;
                    s_d.op_addr   = s_q.areg;
                    s_d.op_data   = s_q.dreg;
                    s_d.from_test = 1'b0;
                end else if (erase_rise) begin
                    s_d.st        = UFA_ST_ERASE;
                    s_d.cnt       = `UFA_CNT_W'(`UFA_ERASE_CYC);
                    s_d.busy      = 1'b1;
                    s_d.op_addr   = s_q.areg;
                    s_d.from_test = 1'b0;
                end else if (test_req.req) begin
                    s_d.op_addr   = test_req.addr;
                    s_d.op_data   = test_req.wdata;
                    s_d.from_test = 1'b1;
                    case (test_req.cmd)
                        UFA_CMD_PROG: begin
                            s_d.st   = UFA_ST_PROG;
                            s_d.cnt  = `UFA_CNT_W'(`UFA_PROG_CYC);
                            s_d.busy = 1'b1;
                        end
                        UFA_CMD_ERASE: begin
                            s_d.st   = UFA_ST_ERASE;
                            s_d.cnt  = `UFA_CNT_W'(`UFA_ERASE_CYC);
                            s_d.busy = 1'b1;
                        end
                        default: begin
                            s_d.tp_rdata = mem_q[test_req.addr];
                            s_d.tp_done  = 1'b1;
                        end
                    endcase
                end
            end
            UFA_ST_PROG, UFA_ST_ERASE: begin
                // Requests during busy are dropped, not queued.
                if (s_q.cnt == `UFA_CNT_W'(1)) begin
                    mem_we      = (s_q.st == UFA_ST_PROG);
                    mem_erase   = (s_q.st == UFA_ST_ERASE);
                    s_d.st      = UFA_ST_IDLE;
                    s_d.busy    = 1'b0;
                    s_d.tp_done = s_q.from_test;
                end else begin
                    s_d.cnt = s_q.cnt - `UFA_CNT_W'(1);
                end
            end
            default: begin
                s_d.st   = UFA_ST_IDLE;
                s_d.busy = 1'b0;
            end
        endcase
    end

    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    // The array has no reset: flash keeps its contents across reset.
    always_ff @(posedge core_clk) begin
        if (mem_we) begin
            mem_q[s_q.op_addr] <= s_q.op_data;
        end
        if (mem_erase) begin
            for (int i = 0; i < `UFA_SECT_WORDS; i++) begin
                // Only words of the chosen sector are touched.
                mem_q[{sector_of(s_q.op_addr), 8'(i)}] <= `UFA_ERASED;
            end
        end
    end

    assign data_reg_serial_out = s_q.dout;
    assign busy                = s_q.busy;
    assign test_done           = s_q.tp_done;
    assign test_rdata          = s_q.tp_rdata;

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!reset_n);

    a_prog_starts_busy: assert property (
        (s_q.st == UFA_ST_IDLE && prog_rise) |=> busy ##[19:21] !busy)
        else $error("program did not hold busy for its time");
    a_prog_writes_word: assert property (
        (s_q.st == UFA_ST_PROG && s_q.cnt == `UFA_CNT_W'(1))
        |=> mem_q[$past(s_q.op_addr)] == $past(s_q.op_data))
        else $error("programmed word not stored");
    a_erase_keeps_other: assert property (
        mem_erase |=> mem_q[{~$past(s_q.op_addr[8]), 8'h00}]
                      == $past(mem_q[{~s_q.op_addr[8], 8'h00}]))
        else $error("erase disturbed the other sector");
    a_erase_clears_word: assert property (
        mem_erase |=> mem_q[$past(s_q.op_addr)] == `UFA_ERASED)
        else $error("erase left a word of its sector");
    // The sum is cut to nine bits so that the wrap to zero compares equal.
    a_addr_increment: assert property (
        (s_q.st == UFA_ST_IDLE && aclk_rise && !fabric.addr_reg_shift_select)
        |=> s_q.areg == ufa_addr_t'($past(s_q.areg) + ufa_addr_t'(1)))
        else $error("address did not increment");
    a_addr_shift_in: assert property (
        (s_q.st == UFA_ST_IDLE && aclk_rise && fabric.addr_reg_shift_select)
        |=> s_q.areg[0] == $past(fabric.addr_reg_serial_in)
            && s_q.areg[8:1] == $past(s_q.areg[7:0]))
        else $error("address shift wrong");
    a_data_load_word: assert property (
        (s_q.st == UFA_ST_IDLE && dclk_rise && !fabric.data_reg_shift_select)
        |=> s_q.dreg == $past(rd_word) && data_reg_serial_out == s_q.dreg[15])
        else $error("data register load wrong");
    a_data_shift_out: assert property (
        (s_q.st == UFA_ST_IDLE && dclk_rise && fabric.data_reg_shift_select)
        |=> s_q.dreg[15:1] == $past(s_q.dreg[14:0])
            && data_reg_serial_out == $past(s_q.dreg[14]))
        else $error("data register shift wrong");
    a_busy_ignores_clk: assert property (
        (busy && dclk_rise) |=> $stable(s_q.dreg))
        else $error("data register moved while busy");
    a_busy_ignores_addr: assert property (
        (busy && aclk_rise) |=> $stable(s_q.areg))
        else $error("address register moved while busy");
    a_test_read_data: assert property (
        (s_q.st == UFA_ST_IDLE && !prog_rise && !erase_rise && test_req.req
         && test_req.cmd == UFA_CMD_READ)
        |=> test_done && test_rdata == $past(mem_q[test_req.addr]))
        else $error("test port read wrong");

    c_prog_done: cover property (s_q.st == UFA_ST_PROG ##1 !busy);
    c_erase_done: cover property (mem_erase);
    c_addr_wrap: cover property (aclk_rise && s_q.areg == 9'h1FF
                                 && !fabric.addr_reg_shift_select);
    c_test_read: cover property (test_done && !$past(busy));

endmodule // ufa_top

// ### test/ufa_fabric_model.sv
// Model of the fabric bridging logic that drives the serial registers.
`timescale 1ns/10ps
module ufa_fabric_model (
    input  wire logic            core_clk,
    input  wire logic            data_reg_serial_out,
    input  wire logic            busy,
    output ufa_pkg::ufa_fabric_s fabric
);
    import ufa_pkg::*;
    logic ignore_busy = 1'b0;
    initial fabric = '0;
    // Clocks wait out busy unless a scenario breaks that on purpose.
    task automatic hold_off();
        while (busy === 1'b1 && !ignore_busy) @(posedge core_clk);
    endtask
    task automatic pulse_a(input logic s, input logic b);
        hold_off();
        @(posedge core_clk);
        fabric.addr_reg_shift_select <= s;
        fabric.addr_reg_serial_in    <= b;
        fabric.addr_reg_clock        <= 1'b1;
        @(posedge core_clk);
        fabric.addr_reg_clock        <= 1'b0;
        fabric.addr_reg_serial_in    <= ~b;
    endtask
    task automatic pulse_d(input logic s, input logic b);
        hold_off();
        @(posedge core_clk);
        fabric.data_reg_shift_select <= s;
        fabric.data_reg_serial_in    <= b;
        fabric.data_reg_clock        <= 1'b1;
        @(posedge core_clk);
        fabric.data_reg_clock        <= 1'b0;
        fabric.data_reg_serial_in    <= ~b;
    endtask
    // Address goes MSB first, nine bits.
    task automatic set_addr(input ufa_addr_t a);
        for (int i = 8; i >= 0; i--) pulse_a(1'b1, a[i]);
    endtask
    // Sixteen shifts leave the first bit at the MSB.
    task automatic write_data(input ufa_word_t w);
        for (int i = 15; i >= 0; i--) pulse_d(1'b1, w[i]);
    endtask
    task automatic read_data(output ufa_word_t w);
        pulse_d(1'b0, 1'b0);
        #1 w[15] = data_reg_serial_out;
        for (int i = 14; i >= 0; i--) begin
            pulse_d(1'b1, 1'b0);
            #1 w[i] = data_reg_serial_out;
        end
    endtask
    // Counts the edges that see busy high.
    task automatic op(input logic prog, output int n);
        hold_off();
        @(posedge core_clk);
        if (prog) fabric.program_req <= 1'b1;
        else fabric.erase_req <= 1'b1;
        @(posedge core_clk);
        fabric.program_req <= 1'b0;
        fabric.erase_req   <= 1'b0;
        n = 0;
        repeat (1000) begin
            @(posedge core_clk);
            if (busy === 1'b1) n++;
            else if (n > 0) break;
        end
    endtask
endmodule // ufa_fabric_model

// ### test/ufa_top_tb_top.sv
// Testbench for the user flash array access block.
`timescale 1ns/10ps
module ufa_top_tb_top;
    import ufa_pkg::*;
    logic          core_clk = 1'b0;
    logic          reset_n = 1'b0;
    ufa_fabric_s   fabric;
    ufa_test_req_s test_req = '0;
    logic          data_reg_serial_out, busy, test_done;
    ufa_word_t     test_rdata, w;
    int            bad_count = 0, tests_run = 0, n;
    always #50 core_clk = ~core_clk;
    ufa_top dut (.core_clk(core_clk), .reset_n(reset_n), .fabric(fabric),
        .test_req(test_req), .data_reg_serial_out(data_reg_serial_out),
        .busy(busy), .test_done(test_done), .test_rdata(test_rdata));
    ufa_fabric_model fab (.core_clk(core_clk), .busy(busy),
        .data_reg_serial_out(data_reg_serial_out), .fabric(fabric));
    task automatic chk(input ufa_word_t got, input ufa_word_t exp);
        tests_run++;
        if (got !== exp) begin
            bad_count++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // One-cycle request, so a done request is never issued twice.
    task automatic tp(input ufa_cmd_e c, input ufa_addr_t a,
                      input ufa_word_t d, input int cyc);
        int k;
        @(posedge core_clk);
        test_req <= '{1'b1, c, a, d};
        @(posedge core_clk);
        test_req.req <= 1'b0;
        for (k = 1; k < 1000; k++) begin
            @(posedge core_clk);
            if (test_done === 1'b1) break;
        end
        w = test_rdata;
        chk(16'(k), 16'(cyc));
    endtask
    task automatic rd(input ufa_addr_t a, input ufa_word_t exp);
        tp(UFA_CMD_READ, a, 16'h0000, 1);
        chk(w, exp);
    endtask
    task automatic sc_fab_prog();
        fab.set_addr(9'h1FF);
        fab.write_data(16'hA5C3);
        fab.op(1'b1, n);
        chk(16'(n), 16'h0014);
        fab.read_data(w);
        chk(w, 16'hA5C3);
        rd(9'h1FF, 16'hA5C3);
    endtask
    task automatic sc_wrap();
        fab.pulse_a(1'b0, 1'b0);
        fab.write_data(16'h0001);
        fab.op(1'b1, n);
        rd(9'h000, 16'h0001);
    endtask
    task automatic sc_sector();
        tp(UFA_CMD_PROG, 9'h0FF, 16'h1234, 21);
        tp(UFA_CMD_PROG, 9'h100, 16'h5678, 21);
        fab.set_addr(9'h17F);
        fab.op(1'b0, n);
        chk(16'(n), 16'h01F4);
        rd(9'h100, 16'hFFFF);
        rd(9'h1FF, 16'hFFFF);
        rd(9'h0FF, 16'h1234);
        rd(9'h000, 16'h0001);
    endtask
    task automatic sc_test_erase();
        tp(UFA_CMD_ERASE, 9'h080, 16'h0000, 501);
        rd(9'h0FF, 16'hFFFF);
        // The spare command code reads like a plain read.
        tp(ufa_cmd_e'(2'b11), 9'h0FF, 16'h0000, 1);
        chk(w, 16'hFFFF);
    endtask
    // Clocks arriving during a program must be dropped.
    task automatic sc_busy();
        fab.set_addr(9'h0AA);
        fab.write_data(16'h3C5A);
        fork
            fab.op(1'b1, n);
            begin
                repeat (3) @(posedge core_clk);
                fab.ignore_busy = 1'b1;
                fab.pulse_a(1'b1, 1'b1);
                fab.pulse_d(1'b1, 1'b1);
                fab.ignore_busy = 1'b0;
            end
        join
        fab.read_data(w);
        chk(w, 16'h3C5A);
    endtask
    // A reset mid-run clears the registers but the array keeps its words.
    task automatic sc_reset();
        rd(9'h0AA, 16'h3C5A);
        @(posedge core_clk);
        reset_n <= 1'b0;
        repeat (2) @(posedge core_clk);
        chk(test_rdata, 16'h0000);
        chk(16'(busy), 16'h0000);
        chk(16'(test_done), 16'h0000);
        reset_n <= 1'b1;
        @(posedge core_clk);
        fab.read_data(w);
        chk(w, 16'hFFFF);
        rd(9'h0AA, 16'h3C5A);
    endtask
    task automatic summarize();
        $display("checks=%0d mismatches=%0d", tests_run, bad_count);
        if (bad_count == 0 && tests_run > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    initial begin
        repeat (20000) @(posedge core_clk);
        bad_count++;
        summarize();
    end
    initial begin
        repeat (16) @(posedge core_clk);
        reset_n <= 1'b1;
        @(posedge core_clk);
        sc_fab_prog();
        sc_wrap();
        sc_sector();
        sc_test_erase();
        sc_busy();
        sc_reset();
        summarize();
    end
endmodule // ufa_top_tb_top
